// File: instr_exec.sv
// Instruction executor for power-down, rotate and bit clear instructions, APB programmed
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_params.svh"

// Function
// - Armed first power-down enters clock mode
// - Unarmed first power-down acts as no-op
// - Armed second power-down enters RAM backup
// - Unarmed second power-down changes no state
// - Rotate accumulator right through carry
// - Clear memory bit j at data pointer
// - Bank clear zeroes table page bit six
// - Bank flag affects only table lookup page
// - Clear port D bit Y, Y 0..7
module instr_exec
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	input wire logic wake,
	input wire logic table_lookup_active,
	output logic table_page_bit6,
	output logic clock_mode,
	output logic ram_backup,
	output logic [3:0] portc_out,
	output logic [7:0] portd_out
);
	import instr_exec_pkg::*;

	dec_type dec;
	pwr_state_type pwr_q, pwr_d;
	logic [3:0] acc_q, acc_d;
	logic carry_q, carry_d;
	logic bank_q, bank_d;
	logic armed_q, armed_d;
	logic [3:0] dp_q, dp_d;
	logic [3:0] y_q, y_d;
	logic [3:0] portc_q, portc_d;
	logic [7:0] portd_q, portd_d;
	logic [3:0] mem_q [16];
	logic [3:0] mem_d [16];
	logic [31:0] prdata_q, rd_word;
	wire setup_ph;
	wire access_ph;
	wire wr_acc;
	wire hit_instr, hit_core, hit_ptr, hit_ports, hit_mem, mapped;
	wire running;
	wire exec;
	wire wr_core, wr_ptr, wr_ports, wr_mem;
	wire y_ok;
	wire [3:0] cur_word;
	logic [9:0] last_op_q;

	// Address decode and bus phases
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_acc = access_ph & pwrite;
	assign hit_instr = (paddr == `OFS_INSTR);
	assign hit_core = (paddr == `OFS_CORE);
	assign hit_ptr = (paddr == `OFS_PTR);
	assign hit_ports = (paddr == `OFS_PORTS);
	assign hit_mem = (paddr == `OFS_MEM);
	assign mapped = hit_instr | hit_core | hit_ptr | hit_ports | hit_mem;
	assign pready = 1'b1;
	assign pslverr = access_ph & ~mapped;
	assign prdata = prdata_q;

	// Write strobes; a stopped core executes nothing
	assign running = (pwr_q == pwr_run);
	assign exec = wr_acc & hit_instr & running;
	assign wr_core = wr_acc & hit_core;
	assign wr_ptr = wr_acc & hit_ptr;
	assign wr_ports = wr_acc & hit_ports;
	assign wr_mem = wr_acc & hit_mem;
	assign y_ok = (y_q <= `PORTD_MAX_IDX);
	assign cur_word = mem_q[dp_q];

	instr_decode u_decode
	(
		.opcode(pwdata[9:0]),
		.dec(dec)
	);

	// Read mux, captured in the setup phase
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit_instr)
			rd_word[9:0] = last_op_q;
		if (hit_core)
		begin
			rd_word[`CORE_ACC_LSB +: 4] = acc_q;
			rd_word[`CORE_CARRY_BIT] = carry_q;
			rd_word[`CORE_BANK_BIT] = bank_q;
			rd_word[`CORE_CLKMODE_BIT] = (pwr_q == pwr_clock);
			rd_word[`CORE_BACKUP_BIT] = (pwr_q == pwr_backup);
			rd_word[`CORE_ARMED_BIT] = armed_q;
		end
		if (hit_ptr)
		begin
			rd_word[`PTR_DP_LSB +: 4] = dp_q;
			rd_word[`PTR_Y_LSB +: 4] = y_q;
		end
		if (hit_ports)
		begin
			rd_word[`PORTS_C_LSB +: 4] = portc_q;
			rd_word[`PORTS_D_LSB +: 8] = portd_q;
		end
		if (hit_mem)
			rd_word[3:0] = cur_word;
	end

	// Accumulator and flags
	assign acc_d = (exec & dec.rotate) ? {carry_q, acc_q[3:1]} :
		wr_core ? pwdata[`CORE_ACC_LSB +: 4] : acc_q;
	assign carry_d = (exec & dec.rotate) ? acc_q[0] :
		(exec & dec.carry_clear) ? 1'b0 :
		wr_core ? pwdata[`CORE_CARRY_BIT] : carry_q;
	assign bank_d = (exec & dec.bank_clear) ? 1'b0 :
		wr_core ? pwdata[`CORE_BANK_BIT] : bank_q;
	// Arming holds only across the very next instruction
	assign armed_d = exec ? dec.arm : armed_q;
	assign dp_d = wr_ptr ? pwdata[`PTR_DP_LSB +: 4] : dp_q;
	assign y_d = wr_ptr ? pwdata[`PTR_Y_LSB +: 4] : y_q;
	assign portc_d = (exec & dec.portc_clear) ? 4'h0 :
		wr_ports ? pwdata[`PORTS_C_LSB +: 4] : portc_q;

	// Bank bit only reaches the table lookup page address
	assign table_page_bit6 = table_lookup_active & bank_q;

	// Port D bits, cleared by index in Y when Y is legal
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_portd
			assign portd_d[i] = (exec & dec.portd_clear & y_ok & (y_q[2:0] == 3'(i))) ? 1'b0 :
				wr_ports ? pwdata[`PORTS_D_LSB + i] : portd_q[i];
		end
	endgenerate

	// Data memory words, bit clear at the data pointer
	generate
		for (genvar e = 0; e < 16; e++)
		begin : g_mem
			wire sel_e = (dp_q == 4'(e));
			assign mem_d[e] = (exec & dec.mem_clear & sel_e) ? (mem_q[e] & ~(4'h1 << dec.bit_sel)) :
				(wr_mem & sel_e) ? pwdata[3:0] : mem_q[e];
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mem_q[e] <= `MEM_RST;
				else
					mem_q[e] <= mem_d[e];
			end
		end
	endgenerate

	// Power state; unarmed power-down falls through as a no-op
	always_comb
	begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			pwr_run:
			begin
				if (exec & dec.clock_mode & armed_q)
					pwr_d = pwr_clock;
				else if (exec & dec.ram_backup & armed_q)
					pwr_d = pwr_backup;
			end
			pwr_clock, pwr_backup:
			begin
				if (wake)
					pwr_d = pwr_run;
			end
			default:
				pwr_d = pwr_run;
		endcase
	end
	assign clock_mode = (pwr_q == pwr_clock);
	assign ram_backup = (pwr_q == pwr_backup);
	assign portc_out = portc_q;
	assign portd_out = portd_q;

	// Core state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_q <= pwr_run;
			acc_q <= `ACC_RST;
			carry_q <= `CARRY_RST;
			bank_q <= `BANK_RST;
			armed_q <= 1'b0;
			dp_q <= `PTR_RST;
			y_q <= `PTR_RST;
			portc_q <= `PORTC_RST;
			portd_q <= `PORTD_RST;
		end
		else
		begin
			pwr_q <= pwr_d;
			acc_q <= acc_d;
			carry_q <= carry_d;
			bank_q <= bank_d;
			armed_q <= armed_d;
			dp_q <= dp_d;
			y_q <= y_d;
			portc_q <= portc_d;
			portd_q <= portd_d;
		end
	end

	// Bus read data and last executed opcode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
			last_op_q <= 10'h000;
		end
		else
		begin
			if (setup_ph)
				prdata_q <= rd_word;
			if (exec)
				last_op_q <= pwdata[9:0];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Instruction executed right after an arming instruction
	sequence s_armed_issue;
		exec && armed_q;
	endsequence

	property p_clock_armed;
		s_armed_issue ##0 dec.clock_mode |=> clock_mode && !ram_backup;
	endproperty
	a_clock_armed: assert property (p_clock_armed) else $error("armed power-down missed clock mode");
	property p_clock_unarmed;
		exec && dec.clock_mode && !armed_q |=> running && $stable(acc_q) && $stable(carry_q);
	endproperty
	a_clock_unarmed: assert property (p_clock_unarmed) else $error("unarmed power-down stopped the core");
	property p_backup_armed;
		s_armed_issue ##0 dec.ram_backup |=> ram_backup && !clock_mode;
	endproperty
	a_backup_armed: assert property (p_backup_armed) else $error("armed power-down missed backup");
	property p_backup_unarmed;
		exec && dec.ram_backup && !armed_q |=> running && $stable(acc_q) && $stable(carry_q)
			&& $stable(bank_q) && $stable(portc_q) && $stable(portd_q) && $stable(cur_word);
	endproperty
	a_backup_unarmed: assert property (p_backup_unarmed) else $error("unarmed backup changed state");
	property p_rotate;
		exec && dec.rotate |=> acc_q == {$past(carry_q), $past(acc_q[3:1])} && carry_q == $past(acc_q[0]);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate through carry wrong");
	property p_mem_clear;
		exec && dec.mem_clear |=> cur_word == ($past(cur_word) & ~(4'h1 << $past(dec.bit_sel)));
	endproperty
	a_mem_clear: assert property (p_mem_clear) else $error("memory bit clear wrong");
	property p_bank_clear;
		exec && dec.bank_clear ##1 table_lookup_active |-> !table_page_bit6;
	endproperty
	a_bank_clear: assert property (p_bank_clear) else $error("bank clear left page bit set");
	property p_bank_only_lookup;
		!table_lookup_active |-> !table_page_bit6;
	endproperty
	a_bank_only_lookup: assert property (p_bank_only_lookup) else $error("page bit outside lookup");
	property p_portd;
		exec && dec.portd_clear |=> portd_q == ($past(y_ok) ? ($past(portd_q) & ~(8'h01 << $past(y_q[2:0])))
			: $past(portd_q));
	endproperty
	a_portd: assert property (p_portd) else $error("port D bit clear wrong");
	property p_carry_clear;
		exec && dec.carry_clear |=> !carry_q && $stable(acc_q) && $stable(cur_word);
	endproperty
	a_carry_clear: assert property (p_carry_clear) else $error("carry clear wrong");
	property p_portc_clear;
		exec && dec.portc_clear |=> portc_out == 4'h0;
	endproperty
	a_portc_clear: assert property (p_portc_clear) else $error("port C not cleared");

endmodule : instr_exec
`default_nettype wire

// File: instr_exec_params.svh
// Register offsets, field positions, reset values and opcodes of the instruction executor
`ifndef INSTR_EXEC_PARAMS_SVH
`define INSTR_EXEC_PARAMS_SVH

// Register byte offsets on the APB
`define OFS_INSTR 12'h000
`define OFS_CORE 12'h004
`define OFS_PTR 12'h008
`define OFS_PORTS 12'h00C
`define OFS_MEM 12'h010

// Field positions in the core status word
`define CORE_ACC_LSB 0
`define CORE_CARRY_BIT 4
`define CORE_BANK_BIT 5
`define CORE_CLKMODE_BIT 8
`define CORE_BACKUP_BIT 9
`define CORE_ARMED_BIT 10

// Field positions in the pointer and port words
`define PTR_DP_LSB 0
`define PTR_Y_LSB 8
`define PORTS_C_LSB 0
`define PORTS_D_LSB 8

// Reset values
`define ACC_RST 4'h0
`define CARRY_RST 1'b0
`define BANK_RST 1'b0
`define PTR_RST 4'h0
`define PORTC_RST 4'hF
`define PORTD_RST 8'hFF
`define MEM_RST 4'h0

// Highest legal port D index held in register Y
`define PORTD_MAX_IDX 4'h7

// Instruction opcodes, ten bits
`define OP_ARM 10'h068
`define OP_CLOCK_MODE 10'h002
`define OP_RAM_BACKUP 10'h008
`define OP_ROTATE_RIGHT 10'h01D
`define OP_MEM_BIT_CLEAR 10'h04C
`define OP_BANK_CLEAR 10'h026
`define OP_CARRY_CLEAR 10'h006
`define OP_PORTC_CLEAR 10'h28C
`define OP_PORTD_BIT_CLEAR 10'h014

`endif

// File: instr_exec_pkg.sv
// Types shared by the instruction executor and its decoder
package instr_exec_pkg;

	// One strobe per decoded instruction, plus the memory bit index
	typedef struct packed {
		logic arm;
		logic clock_mode;
		logic ram_backup;
		logic rotate;
		logic mem_clear;
		logic bank_clear;
		logic carry_clear;
		logic portc_clear;
		logic portd_clear;
		logic [1:0] bit_sel;
	} dec_type;

	// Power state of the core
	typedef enum logic [1:0] {
		pwr_run,
		pwr_clock,
		pwr_backup
	} pwr_state_type;

endpackage : instr_exec_pkg

// File: instr_decode.sv
// Opcode decoder for the instruction executor
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_params.svh"

module instr_decode
(
	// Opcode in
	input wire logic [9:0] opcode,
	// Decoded strobes out
	output instr_exec_pkg::dec_type dec
);
	import instr_exec_pkg::*;

	// Full opcode of the memory bit clear, index bits included
	localparam logic [9:0] mem_clear_op = `OP_MEM_BIT_CLEAR;

	// Exact matches, memory bit clear ignores its two index bits
	assign dec.arm = (opcode == `OP_ARM);
	assign dec.clock_mode = (opcode == `OP_CLOCK_MODE);
	assign dec.ram_backup = (opcode == `OP_RAM_BACKUP);
	assign dec.rotate = (opcode == `OP_ROTATE_RIGHT);
	assign dec.mem_clear = (opcode[9:2] == mem_clear_op[9:2]);
	assign dec.bank_clear = (opcode == `OP_BANK_CLEAR);
	assign dec.carry_clear = (opcode == `OP_CARRY_CLEAR);
	assign dec.portc_clear = (opcode == `OP_PORTC_CLEAR);
	assign dec.portd_clear = (opcode == `OP_PORTD_BIT_CLEAR);
	assign dec.bit_sel = opcode[1:0];

endmodule : instr_decode
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the instruction executor
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_params.svh"

module tb_top;
	// Stimulus and observed signals
	logic pclk, presetn, psel, penable, pwrite, wake, table_lookup_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, table_page_bit6, clock_mode, ram_backup;
	logic [3:0] portc_out;
	logic [7:0] portd_out;
	int failures, checks_done;

	// Design under test
	instr_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake(wake),
		.table_lookup_active(table_lookup_active), .table_page_bit6(table_page_bit6),
		.clock_mode(clock_mode), .ram_backup(ram_backup), .portc_out(portc_out), .portd_out(portd_out));

	// Clock, 10 ns period
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic report_and_stop;
		$display("Checks done %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	// One APB transfer, bounded wait for pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1)
		begin
			failures++;
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Execute one opcode
	task automatic exec(input logic [9:0] op);
		apb(1'b1, `OFS_INSTR, {22'h0, op});
	endtask : exec

	// Read a register and compare
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp, msg);
	endtask : rdchk

	// Power state as a two-bit value, sampled mid-cycle
	task automatic pwr_chk(input logic [31:0] exp, input string msg);
		@(negedge pclk);
		chk({30'h0, clock_mode, ram_backup}, exp, msg);
	endtask : pwr_chk

	// Wake pulse of one cycle
	task automatic wake_up;
		@(posedge pclk);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		pwr_chk(32'h0000_0000, "woken");
	endtask : wake_up

	// Reset values and unmapped access
	task automatic t_reset;
		rdchk(`OFS_PORTS, 32'h0000_FF0F, "ports after reset");
		rdchk(`OFS_CORE, 32'h0000_0000, "core after reset");
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001, "unmapped error");
	endtask : t_reset

	// Rotate through carry twice, then carry clear
	task automatic t_rotate;
		apb(1'b1, `OFS_CORE, 32'h0000_0016);
		exec(`OP_ROTATE_RIGHT);
		rdchk(`OFS_CORE, 32'h0000_000B, "rotate carry in");
		exec(`OP_ROTATE_RIGHT);
		rdchk(`OFS_CORE, 32'h0000_0015, "rotate carry out");
		apb(1'b1, `OFS_CORE, 32'h0000_001A);
		exec(`OP_CARRY_CLEAR);
		rdchk(`OFS_CORE, 32'h0000_000A, "carry clear");
	endtask : t_rotate

	// Every bit index of the memory bit clear
	task automatic t_membit;
		apb(1'b1, `OFS_PTR, 32'h0000_0005);
		for (int j = 0; j < 4; j++)
		begin
			apb(1'b1, `OFS_MEM, 32'h0000_000F);
			exec(`OP_MEM_BIT_CLEAR | 10'(j));
			rdchk(`OFS_MEM, 32'h0000_000F & ~(32'h1 << j), "memory bit clear");
		end
	endtask : t_membit

	// Bank flag steers only the table page bit
	task automatic t_bank;
		apb(1'b1, `OFS_CORE, 32'h0000_0020);
		@(negedge pclk);
		chk({31'h0, table_page_bit6}, 32'h0000_0000, "page bit outside lookup");
		@(posedge pclk);
		table_lookup_active <= 1'b1;
		@(negedge pclk);
		chk({31'h0, table_page_bit6}, 32'h0000_0001, "page bit in lookup");
		exec(`OP_BANK_CLEAR);
		@(negedge pclk);
		chk({31'h0, table_page_bit6}, 32'h0000_0000, "page bit after clear");
		rdchk(`OFS_CORE, 32'h0000_0000, "bank flag cleared");
		table_lookup_active <= 1'b0;
	endtask : t_bank

	// Port C clear and port D bit clear for Y 0 to 8
	task automatic t_ports;
		exec(`OP_PORTC_CLEAR);
		@(negedge pclk);
		chk({28'h0, portc_out}, 32'h0000_0000, "port C clear");
		for (int y = 0; y < 9; y++)
		begin
			apb(1'b1, `OFS_PORTS, 32'h0000_FF00);
			apb(1'b1, `OFS_PTR, 32'(y) << 8);
			exec(`OP_PORTD_BIT_CLEAR);
			@(negedge pclk);
			chk({24'h0, portd_out}, (y < 8) ? (32'h0000_00FF & ~(32'h1 << y)) : 32'h0000_00FF, "port D bit");
		end
	endtask : t_ports

	// Power-down with and without arming
	task automatic t_power;
		apb(1'b1, `OFS_CORE, 32'h0000_0013);
		exec(`OP_CLOCK_MODE);
		pwr_chk(32'h0000_0000, "unarmed clock mode");
		exec(`OP_RAM_BACKUP);
		pwr_chk(32'h0000_0000, "unarmed backup");
		rdchk(`OFS_CORE, 32'h0000_0013, "unarmed leaves state");
		exec(`OP_ARM);
		exec(`OP_CARRY_CLEAR);
		exec(`OP_CLOCK_MODE);
		pwr_chk(32'h0000_0000, "arm not adjacent");
		apb(1'b1, `OFS_PTR, 32'h0000_0000);
		apb(1'b1, `OFS_MEM, 32'h0000_0009);
		exec(`OP_ARM);
		exec(`OP_CLOCK_MODE);
		pwr_chk(32'h0000_0002, "armed clock mode");
		wake_up();
		exec(`OP_ARM);
		exec(`OP_RAM_BACKUP);
		pwr_chk(32'h0000_0001, "armed backup");
		wake_up();
		rdchk(`OFS_MEM, 32'h0000_0009, "memory kept in backup");
	endtask : t_power

	// Main sequence
	initial
	begin
		failures = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		wake = 1'b0;
		table_lookup_active = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rotate();
		t_membit();
		t_bank();
		t_ports();
		t_power();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
